// >>> stc_pkg.sv
package stc_pkg;

   // Clock and time base.
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned MS_PS = 1000000000;
   localparam int unsigned CYC_PER_MS = MS_PS / CLK_PERIOD_PS;

   // Register byte offsets.
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_TIMEOUT = 12'h004;
   localparam logic [11:0] OFS_DELAY = 12'h008;
   localparam logic [11:0] OFS_REPEAT = 12'h00C;
   localparam logic [11:0] OFS_BUFDEPTH = 12'h010;
   localparam logic [11:0] OFS_TCPPORT = 12'h014;
   localparam logic [11:0] OFS_STATUS = 12'h018;

   // Control register fields.
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_OP_BIT = 1;
   localparam int unsigned CTRL_WM_LSB = 2;

   // Status register fields.
   localparam int unsigned ST_REMAIN_LSB = 0;
   localparam int unsigned ST_ACTIVE_BIT = 8;
   localparam int unsigned ST_STATE_LSB = 9;
   localparam int unsigned ST_CAUSE_LSB = 11;
   localparam int unsigned ST_CMD_BIT = 13;

   // Reset values and limits.
   localparam logic RST_ENABLE = 1'b1;
   localparam logic [15:0] RST_TIMEOUT_MS = 16'h03E8;
   localparam logic [13:0] RST_DELAY_MS = 14'h01F4;
   localparam logic [13:0] MAX_DELAY_MS = 14'h2710;
   localparam logic [7:0] RST_REPEAT = 8'h02;
   localparam logic [3:0] RST_BUFDEPTH = 4'h1;
   localparam logic [3:0] MIN_BUFDEPTH = 4'h1;
   localparam logic [3:0] MAX_BUFDEPTH = 4'hA;
   localparam logic [15:0] RST_TCPPORT = 16'hD7D8;

   // Remote command bytes.
   localparam logic [7:0] BYTE_SYN = 8'h16;
   localparam logic [7:0] BYTE_ON = 8'h54;
   localparam logic [7:0] BYTE_OFF = 8'h55;
   localparam logic [7:0] BYTE_CR = 8'h0D;

   typedef enum logic {OP_INTERNAL, OP_EXTERNAL} stc_op_e;
   typedef enum logic [1:0] {WM_SINGLE, WM_BURST, WM_SYNC, WM_LATCHED} stc_work_e;
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CAPTURE, ST_SEARCH} stc_state_e;
   typedef enum logic [1:0] {END_NONE, END_DECODED, END_TIMEOUT, END_ABORTED} stc_cause_e;
   typedef enum logic [1:0] {CM_IDLE, CM_SYN, CM_ON, CM_OFF} stc_cmd_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } stc_apb_req_s;

   typedef struct packed {
      logic valid;
      logic [15:0] port;
      logic [7:0] data;
   } stc_rx_s;

   typedef struct packed {
      logic capture;
      logic active;
      logic abort;
      logic decoded;
      logic timeout;
   } stc_scan_s;

endpackage

// >>> stc_top.sv
`timescale 1ns/1ps
// Function
// - Internal mode: restart read at every interval
// - Pulse or held level both trigger
// - Zero delay: search starts at once
// - Serial or network command also triggers
// - Single mode: one capture, one decode for trigger-input reads
// - Burst keeps searching after input removal
// - Sync mode: release aborts trigger-input read immediately
// - Sync mode: decode or timeout ends read
// - Latched default: hold until decode/timeout
// - Burst repeats configured count, default two
// - Each burst cycle bounded by read timeout
// - Trigger delay 0..10000 ms, default 500
// - Zero delay adds no wait
// - Image buffer depth 1..10, default 1
// - Bytes 16 54 0D mean trigger on
// - Bytes 16 55 0D mean trigger off
// - Command read ends: decode, off, timeout
// - Network commands only on configured port
module stc_top #(
   parameter int unsigned P_CYC_PER_MS = stc_pkg::CYC_PER_MS
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire stc_pkg::stc_apb_req_s i_apb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_ext_trig,
   input wire stc_pkg::stc_rx_s i_serial_rx,
   input wire stc_pkg::stc_rx_s i_net_rx,
   input wire logic i_dec_done,
   input wire logic i_dec_ok,
   output stc_pkg::stc_scan_s o_scan,
   output logic [3:0] o_buf_depth,
   output logic [15:0] o_tcp_port
);

   function automatic stc_pkg::stc_cmd_e cmd_step(input stc_pkg::stc_cmd_e st, input logic [7:0] b);
      stc_pkg::stc_cmd_e nx;
      nx = stc_pkg::CM_IDLE;
      if (b == stc_pkg::BYTE_SYN) begin
         nx = stc_pkg::CM_SYN;
      end else if (st == stc_pkg::CM_SYN && b == stc_pkg::BYTE_ON) begin
         nx = stc_pkg::CM_ON;
      end else if (st == stc_pkg::CM_SYN && b == stc_pkg::BYTE_OFF) begin
         nx = stc_pkg::CM_OFF;
      end
      return nx;
   endfunction

   function automatic logic [13:0] clamp14(input logic [31:0] v, input logic [13:0] lo, input logic [13:0] hi);
      logic [13:0] r;
      r = v[13:0];
      if (v < {18'h00000, lo}) begin
         r = lo;
      end else if (v > {18'h00000, hi}) begin
         r = hi;
      end
      return r;
   endfunction

   // Configuration registers.
   logic enable_r;
   stc_pkg::stc_op_e op_r;
   stc_pkg::stc_work_e wm_r;
   logic [15:0] timeout_r;
   logic [13:0] delay_r;
   logic [7:0] repeat_r;
   logic [3:0] bufdepth_r;
   logic [15:0] tcpport_r;

   // Control state.
   stc_pkg::stc_state_e state_r;
   stc_pkg::stc_state_e state_nxt;
   stc_pkg::stc_cause_e cause_r;
   stc_pkg::stc_cause_e cause_nxt;
   logic [7:0] remain_r;
   logic [7:0] remain_nxt;
   logic cmd_r;
   logic cmd_nxt;
   logic trig_d_r;
   stc_pkg::stc_cmd_e ser_cm_r;
   stc_pkg::stc_cmd_e net_cm_r;
   logic [31:0] pre_r;
   logic [15:0] ms_r;
   logic restart;
   stc_pkg::stc_scan_s scan_nxt;

   // APB decode.
   logic setup_ph;
   logic wr_en;
   logic mapped;
   logic [31:0] rdata;
   logic [31:0] status_w;

   assign setup_ph = i_apb.psel && !i_apb.penable;
   assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
   assign o_pready = 1'b1;

   always_comb begin
      mapped = 1'b1;
      if (i_apb.paddr == stc_pkg::OFS_CTRL) begin
         mapped = 1'b1;
      end else if (i_apb.paddr == stc_pkg::OFS_TIMEOUT) begin
         mapped = 1'b1;
      end else if (i_apb.paddr == stc_pkg::OFS_DELAY) begin
         mapped = 1'b1;
      end else if (i_apb.paddr == stc_pkg::OFS_REPEAT) begin
         mapped = 1'b1;
      end else if (i_apb.paddr == stc_pkg::OFS_BUFDEPTH) begin
         mapped = 1'b1;
      end else if (i_apb.paddr == stc_pkg::OFS_TCPPORT) begin
         mapped = 1'b1;
      end else if (i_apb.paddr == stc_pkg::OFS_STATUS) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   assign o_pslverr = i_apb.psel && i_apb.penable && !mapped;

   always_comb begin
      status_w = 32'h00000000;
      status_w[stc_pkg::ST_REMAIN_LSB +: 8] = remain_r;
      status_w[stc_pkg::ST_ACTIVE_BIT] = o_scan.active;
      status_w[stc_pkg::ST_STATE_LSB +: 2] = state_r;
      status_w[stc_pkg::ST_CAUSE_LSB +: 2] = cause_r;
      status_w[stc_pkg::ST_CMD_BIT] = cmd_r;
   end

   always_comb begin
      rdata = 32'h00000000;
      if (i_apb.paddr == stc_pkg::OFS_CTRL) begin
         rdata[stc_pkg::CTRL_ENABLE_BIT] = enable_r;
         rdata[stc_pkg::CTRL_OP_BIT] = op_r;
         rdata[stc_pkg::CTRL_WM_LSB +: 2] = wm_r;
      end else if (i_apb.paddr == stc_pkg::OFS_TIMEOUT) begin
         rdata[15:0] = timeout_r;
      end else if (i_apb.paddr == stc_pkg::OFS_DELAY) begin
         rdata[13:0] = delay_r;
      end else if (i_apb.paddr == stc_pkg::OFS_REPEAT) begin
         rdata[7:0] = repeat_r;
      end else if (i_apb.paddr == stc_pkg::OFS_BUFDEPTH) begin
         rdata[3:0] = bufdepth_r;
      end else if (i_apb.paddr == stc_pkg::OFS_TCPPORT) begin
         rdata[15:0] = tcpport_r;
      end else if (i_apb.paddr == stc_pkg::OFS_STATUS) begin
         rdata = status_w;
      end
   end

   // Read data is captured in the setup cycle and stands through the access cycle.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_prdata <= 32'h00000000;
      end else if (setup_ph && !i_apb.pwrite) begin
         o_prdata <= rdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         enable_r <= stc_pkg::RST_ENABLE;
         op_r <= stc_pkg::OP_EXTERNAL;
         wm_r <= stc_pkg::WM_LATCHED;
         timeout_r <= stc_pkg::RST_TIMEOUT_MS;
         delay_r <= stc_pkg::RST_DELAY_MS;
         repeat_r <= stc_pkg::RST_REPEAT;
         bufdepth_r <= stc_pkg::RST_BUFDEPTH;
         tcpport_r <= stc_pkg::RST_TCPPORT;
      end else if (wr_en) begin
         if (i_apb.paddr == stc_pkg::OFS_CTRL) begin
            enable_r <= i_apb.pwdata[stc_pkg::CTRL_ENABLE_BIT];
            op_r <= stc_pkg::stc_op_e'(i_apb.pwdata[stc_pkg::CTRL_OP_BIT]);
            wm_r <= stc_pkg::stc_work_e'(i_apb.pwdata[stc_pkg::CTRL_WM_LSB +: 2]);
         end else if (i_apb.paddr == stc_pkg::OFS_TIMEOUT) begin
            timeout_r <= i_apb.pwdata[15:0];
         end else if (i_apb.paddr == stc_pkg::OFS_DELAY) begin
            delay_r <= clamp14(i_apb.pwdata, 14'h0000, stc_pkg::MAX_DELAY_MS);
         end else if (i_apb.paddr == stc_pkg::OFS_REPEAT) begin
            repeat_r <= i_apb.pwdata[7:0];
         end else if (i_apb.paddr == stc_pkg::OFS_BUFDEPTH) begin
            bufdepth_r <= 4'(clamp14(i_apb.pwdata, {10'h000, stc_pkg::MIN_BUFDEPTH},
                                     {10'h000, stc_pkg::MAX_BUFDEPTH}));
         end else if (i_apb.paddr == stc_pkg::OFS_TCPPORT) begin
            tcpport_r <= i_apb.pwdata[15:0];
         end
      end
   end

   assign o_buf_depth = bufdepth_r;
   assign o_tcp_port = tcpport_r;

   // Remote command recognisers, one per source so that interleaved bytes do not mix.
   logic net_ok;
   logic ser_on;
   logic ser_off;
   logic net_on;
   logic net_off;
   logic cmd_on;
   logic cmd_off;

   assign net_ok = i_net_rx.valid && (i_net_rx.port == tcpport_r);
   assign ser_on = i_serial_rx.valid && ser_cm_r == stc_pkg::CM_ON && i_serial_rx.data == stc_pkg::BYTE_CR;
   assign ser_off = i_serial_rx.valid && ser_cm_r == stc_pkg::CM_OFF && i_serial_rx.data == stc_pkg::BYTE_CR;
   assign net_on = net_ok && net_cm_r == stc_pkg::CM_ON && i_net_rx.data == stc_pkg::BYTE_CR;
   assign net_off = net_ok && net_cm_r == stc_pkg::CM_OFF && i_net_rx.data == stc_pkg::BYTE_CR;
   assign cmd_on = ser_on || net_on;
   assign cmd_off = ser_off || net_off;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ser_cm_r <= stc_pkg::CM_IDLE;
      end else if (i_serial_rx.valid) begin
         ser_cm_r <= cmd_step(ser_cm_r, i_serial_rx.data);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         net_cm_r <= stc_pkg::CM_IDLE;
      end else if (net_ok) begin
         net_cm_r <= cmd_step(net_cm_r, i_net_rx.data);
      end
   end

   // Trigger input edges; a held level shows as its rising edge.
   logic trig_rise;
   logic trig_fall;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         trig_d_r <= 1'b0;
      end else begin
         trig_d_r <= i_ext_trig;
      end
   end

   assign trig_rise = i_ext_trig && !trig_d_r;
   assign trig_fall = !i_ext_trig && trig_d_r;

   // Millisecond time base, restarted by the sequencer.
   logic ms_tick;
   assign ms_tick = (pre_r == P_CYC_PER_MS - 1);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pre_r <= 32'h00000000;
         ms_r <= 16'h0000;
      end else if (restart) begin
         pre_r <= 32'h00000000;
         ms_r <= 16'h0000;
      end else if (ms_tick) begin
         pre_r <= 32'h00000000;
         if (ms_r != 16'hFFFF) begin
            ms_r <= ms_r + 16'h0001;
         end
      end else begin
         pre_r <= pre_r + 32'h00000001;
      end
   end

   logic tmo_hit;
   logic delay_hit;
   logic start_evt;
   logic stop_ext;
   assign tmo_hit = (ms_r >= timeout_r) && (timeout_r != 16'h0000);
   assign delay_hit = (ms_r >= {2'b00, delay_r});
   assign start_evt = op_r == stc_pkg::OP_EXTERNAL && (trig_rise || cmd_on);
   assign stop_ext = op_r == stc_pkg::OP_EXTERNAL
                     && (cmd_off || (wm_r == stc_pkg::WM_SYNC && !cmd_r && trig_fall));

   // Read sequencer.
   always_comb begin
      state_nxt = state_r;
      cause_nxt = cause_r;
      remain_nxt = remain_r;
      cmd_nxt = cmd_r;
      restart = 1'b0;
      scan_nxt = '0;
      case (state_r)
         stc_pkg::ST_IDLE: begin
            if (op_r == stc_pkg::OP_INTERNAL) begin
               if (tmo_hit) begin
                  state_nxt = stc_pkg::ST_CAPTURE;
                  restart = 1'b1;
               end
            end else if (start_evt) begin
               cmd_nxt = !trig_rise;
               remain_nxt = (wm_r == stc_pkg::WM_BURST && repeat_r > 8'h01) ? repeat_r : 8'h01;
               restart = 1'b1;
               if (delay_r == 14'h0000) begin
                  state_nxt = stc_pkg::ST_CAPTURE;
               end else begin
                  state_nxt = stc_pkg::ST_DELAY;
               end
            end
         end
         stc_pkg::ST_DELAY: begin
            if (stop_ext) begin
               state_nxt = stc_pkg::ST_IDLE;
               cause_nxt = stc_pkg::END_ABORTED;
               scan_nxt.abort = 1'b1;
            end else if (delay_hit) begin
               state_nxt = stc_pkg::ST_CAPTURE;
               restart = 1'b1;
            end
         end
         stc_pkg::ST_CAPTURE: begin
            if (stop_ext) begin
               state_nxt = stc_pkg::ST_IDLE;
               cause_nxt = stc_pkg::END_ABORTED;
               scan_nxt.abort = 1'b1;
            end else begin
               scan_nxt.capture = 1'b1;
               state_nxt = stc_pkg::ST_SEARCH;
            end
         end
         stc_pkg::ST_SEARCH: begin
            if (op_r == stc_pkg::OP_INTERNAL) begin
               if (i_dec_done && i_dec_ok) begin
                  scan_nxt.decoded = 1'b1;
                  cause_nxt = stc_pkg::END_DECODED;
               end
               if (tmo_hit) begin
                  state_nxt = stc_pkg::ST_CAPTURE;
                  restart = 1'b1;
               end
            end else if (stop_ext) begin
               state_nxt = stc_pkg::ST_IDLE;
               cause_nxt = stc_pkg::END_ABORTED;
               scan_nxt.abort = 1'b1;
            end else if (i_dec_done && i_dec_ok) begin
               state_nxt = stc_pkg::ST_IDLE;
               cause_nxt = stc_pkg::END_DECODED;
               scan_nxt.decoded = 1'b1;
            end else if (wm_r == stc_pkg::WM_BURST && (tmo_hit || i_dec_done)) begin
               if (remain_r > 8'h01) begin
                  remain_nxt = remain_r - 8'h01;
                  state_nxt = stc_pkg::ST_CAPTURE;
                  restart = 1'b1;
               end else begin
                  state_nxt = stc_pkg::ST_IDLE;
                  cause_nxt = stc_pkg::END_TIMEOUT;
                  scan_nxt.timeout = 1'b1;
               end
            end else if (tmo_hit) begin
               state_nxt = stc_pkg::ST_IDLE;
               cause_nxt = stc_pkg::END_TIMEOUT;
               scan_nxt.timeout = 1'b1;
            end else if (i_dec_done) begin
               if (wm_r == stc_pkg::WM_SINGLE && !cmd_r) begin
                  state_nxt = stc_pkg::ST_IDLE;
                  cause_nxt = stc_pkg::END_TIMEOUT;
                  scan_nxt.timeout = 1'b1;
               end else begin
                  state_nxt = stc_pkg::ST_CAPTURE;
               end
            end
         end
         default: begin
            state_nxt = stc_pkg::ST_IDLE;
         end
      endcase
      if (!enable_r) begin
         state_nxt = stc_pkg::ST_IDLE;
         scan_nxt = '0;
         restart = 1'b1;
      end
      scan_nxt.active = (state_nxt == stc_pkg::ST_CAPTURE) || (state_nxt == stc_pkg::ST_SEARCH);
   end

   // Triggers in DELAY, CAPTURE and SEARCH are not taken; only stop events act there.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= stc_pkg::ST_IDLE;
         cause_r <= stc_pkg::END_NONE;
         remain_r <= 8'h00;
         cmd_r <= 1'b0;
         o_scan <= '0;
      end else begin
         state_r <= state_nxt;
         cause_r <= cause_nxt;
         remain_r <= remain_nxt;
         cmd_r <= cmd_nxt;
         o_scan <= scan_nxt;
      end
   end

endmodule // stc_top

// >>> stc_top_asserts.sv
`timescale 1ns/1ps
module stc_top_asserts #(
   parameter int unsigned P_CYC_PER_MS = stc_pkg::CYC_PER_MS
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire stc_pkg::stc_apb_req_s i_apb,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_ext_trig,
   input wire stc_pkg::stc_rx_s i_serial_rx,
   input wire stc_pkg::stc_rx_s i_net_rx,
   input wire logic i_dec_done,
   input wire logic i_dec_ok,
   input wire stc_pkg::stc_scan_s o_scan,
   input wire logic [3:0] o_buf_depth,
   input wire logic [15:0] o_tcp_port
);
   logic ext_r;
   logic [1:0] mode_r;
   logic dly0_r;
   logic wr_en;
   logic end_any;
   assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
   assign end_any = o_scan.abort || o_scan.decoded || o_scan.timeout;
   // Shadow copy of the trigger setup, followed from the register writes.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ext_r <= 1'b1;
         mode_r <= 2'h3;
      end else if (wr_en && i_apb.paddr == stc_pkg::OFS_CTRL) begin
         ext_r <= i_apb.pwdata[0] && i_apb.pwdata[1];
         mode_r <= i_apb.pwdata[3:2];
      end
   end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dly0_r <= 1'b0;
      end else if (wr_en && i_apb.paddr == stc_pkg::OFS_DELAY) begin
         dly0_r <= i_apb.pwdata[13:0] == 14'h0000;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   a_trig_start: assert property ($rose(i_ext_trig) && !o_scan.active && ext_r && dly0_r
      |-> ##2 o_scan.capture) else $error("capture late after trigger");
   a_sync_release: assert property (ext_r && mode_r == 2'h2 && o_scan.active && $fell(i_ext_trig)
      |=> o_scan.abort) else $error("release did not abort");
   a_decode_end: assert property (o_scan.active && i_dec_done && i_dec_ok
      && !(mode_r == 2'h2 && $fell(i_ext_trig)) |=> o_scan.decoded) else $error("decode did not end read");
   a_single_fail: assert property (ext_r && mode_r == 2'h0 && o_scan.active && i_dec_done && !i_dec_ok
      |=> o_scan.timeout) else $error("single read not ended");
   a_end_clears: assert property (ext_r && end_any |-> !o_scan.active) else $error("active after end");
   a_end_onehot: assert property ($onehot0({o_scan.abort, o_scan.decoded, o_scan.timeout}))
      else $error("two end causes at once");
   a_capture_pulse: assert property (o_scan.capture |=> !o_scan.capture) else $error("capture too long");
   a_ready_high: assert property (o_pready) else $error("pready low");
   a_err_unmapped: assert property (i_apb.psel && i_apb.penable && i_apb.paddr > stc_pkg::OFS_STATUS
      |-> o_pslverr) else $error("no error on unmapped address");
   a_err_idle: assert property (!(i_apb.psel && i_apb.penable) |-> !o_pslverr) else $error("stray pslverr");
   a_depth_range: assert property (o_buf_depth >= 4'h1 && o_buf_depth <= 4'hA)
      else $error("buffer depth out of range");
endmodule // stc_top_asserts

bind stc_top stc_top_asserts #(.P_CYC_PER_MS(P_CYC_PER_MS)) chk_u (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .i_ext_trig(i_ext_trig), .i_serial_rx(i_serial_rx), .i_net_rx(i_net_rx),
   .i_dec_done(i_dec_done), .i_dec_ok(i_dec_ok), .o_scan(o_scan), .o_buf_depth(o_buf_depth),
   .o_tcp_port(o_tcp_port)
);

// >>> stc_host_model.sv
`timescale 1ns/1ps
module stc_host_model (
   input wire logic i_clk,
   output stc_pkg::stc_rx_s o_serial_rx,
   output stc_pkg::stc_rx_s o_net_rx
);
   initial begin
      o_serial_rx = '0;
      o_net_rx = '0;
   end
   // Only the fixed on and off codes are sent, so the two commands never coincide.
   task automatic send(input logic net, input logic [7:0] mid, input logic [15:0] port, input int gap);
      logic [7:0] seq [3];
      seq = '{stc_pkg::BYTE_SYN, mid, stc_pkg::BYTE_CR};
      for (int i = 0; i < 3; i++) begin
         if (net) begin
            o_net_rx <= '{1'b1, port, seq[i]};
         end else begin
            o_serial_rx <= '{1'b1, 16'($urandom), seq[i]};
         end
         @(posedge i_clk);
         // A released line shows the inverse of its last byte.
         if (net) begin
            o_net_rx <= '{1'b0, port, ~seq[i]};
         end else begin
            o_serial_rx <= '{1'b0, 16'($urandom), ~seq[i]};
         end
         // No wait after the last byte, so the caller sees the reaction that follows it.
         if (i < 2) begin
            repeat (gap + 1) @(posedge i_clk);
         end
      end
   endtask
endmodule // stc_host_model

// >>> scan_trigger_controller_tb_top.sv
`timescale 1ns/1ps
module scan_trigger_controller_tb_top;
   localparam int unsigned CPM = 10;
   localparam logic [11:0] OFS [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C};
   localparam logic [32:0] RV [8] = '{33'hF, 33'h3E8, 33'h1F4, 33'h2, 33'h1, 33'hD7D8, 33'h0, 33'h100000000};
   logic i_clk;
   logic i_nrst;
   stc_pkg::stc_apb_req_s apb_r;
   logic [31:0] prdata;
   logic pready, pslverr, ext_trig_r, dec_done_r, dec_ok_r;
   stc_pkg::stc_rx_s ser_rx, net_rx;
   stc_pkg::stc_scan_s scan;
   logic [3:0] buf_depth;
   logic [15:0] tcp_port;
   int errors, samples_checked, cyc, cap_n, n, n0;
   logic ends_on;
   logic [2:0] exp_q[$];
   logic [32:0] rd_q[$];

   stc_top #(.P_CYC_PER_MS(CPM)) dut_u (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_apb(apb_r), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_ext_trig(ext_trig_r), .i_serial_rx(ser_rx), .i_net_rx(net_rx),
      .i_dec_done(dec_done_r), .i_dec_ok(dec_ok_r), .o_scan(scan), .o_buf_depth(buf_depth),
      .o_tcp_port(tcp_port)
   );
   stc_host_model host_u (.i_clk(i_clk), .o_serial_rx(ser_rx), .o_net_rx(net_rx));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   task check(input logic [32:0] got, input logic [32:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task stop_test;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      apb_r <= '{1'b1, 1'b0, wr, a, d};
      @(posedge i_clk);
      apb_r.penable <= 1'b1;
      @(posedge i_clk);
      while (!pready) @(posedge i_clk);
      apb_r <= '{1'b0, 1'b0, 1'($urandom), 12'($urandom), $urandom};
      @(posedge i_clk);
   endtask

   task rd(input logic [11:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h00000000);
   endtask

   task dec(input logic ok);
      repeat (3 + $urandom % 6) @(posedge i_clk);
      dec_done_r <= 1'b1;
      dec_ok_r <= ok;
      @(posedge i_clk);
      dec_done_r <= 1'b0;
      dec_ok_r <= 1'($urandom);
      @(posedge i_clk);
   endtask

   task pulse;
      ext_trig_r <= 1'b1;
      @(posedge i_clk);
      ext_trig_r <= 1'b0;
   endtask

   task wait_cap;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (!scan.capture);
      @(posedge i_clk);
   endtask

   task wait_end;
      while (exp_q.size() != 0) @(negedge i_clk);
      @(posedge i_clk);
   endtask

   // Captures are counted mid-cycle so that a count read at a clock edge is already settled.
   always @(negedge i_clk) begin
      if (scan.capture) cap_n++;
   end

   // Results are compared in the order the stimulus noted them.
   always @(posedge i_clk) begin
      cyc++;
      if (ends_on && (scan.abort || scan.decoded || scan.timeout)) begin
         if (exp_q.size() == 0) check(33'h1, 33'h0);
         else check({30'h0, scan.abort, scan.decoded, scan.timeout}, {30'h0, exp_q.pop_front()});
      end
      if (apb_r.psel && apb_r.penable && pready && !apb_r.pwrite) check({pslverr, prdata}, rd_q.pop_front());
      if (cyc == 20000) begin
         errors++;
         stop_test;
      end
   end

   initial begin
      {errors, samples_checked, cyc, cap_n} = '0;
      apb_r = '0;
      {ext_trig_r, dec_done_r, dec_ok_r, i_nrst} = '0;
      ends_on = 1'b1;
      void'($urandom(32'h5DC8847B));
      repeat (6) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      check({28'h0, scan}, 33'h0);
      check({17'h0, tcp_port}, 33'hD7D8);
      for (int i = 0; i < 8; i++) rd(OFS[i], RV[i]);
      apb(1'b1, stc_pkg::OFS_DELAY, 32'h00003000);
      rd(stc_pkg::OFS_DELAY, 33'h2710);
      apb(1'b1, stc_pkg::OFS_BUFDEPTH, 32'h0);
      rd(stc_pkg::OFS_BUFDEPTH, 33'h1);
      apb(1'b1, stc_pkg::OFS_BUFDEPTH, 32'hF);
      rd(stc_pkg::OFS_BUFDEPTH, 33'hA);
      check({29'h0, buf_depth}, 33'hA);
      apb(1'b1, stc_pkg::OFS_TIMEOUT, 32'd20);
      apb(1'b1, stc_pkg::OFS_DELAY, 32'd3);
      exp_q.push_back(3'b010);
      pulse();
      wait_cap();
      check({32'h0, n >= 31 && n <= 34}, 33'h1);
      dec(1'b1);
      wait_end();
      apb(1'b1, stc_pkg::OFS_DELAY, 32'd0);
      exp_q.push_back(3'b010);
      ext_trig_r <= 1'b1;
      wait_cap();
      check(n, 33'h3);
      n0 = cap_n;
      dec(1'b0);
      wait_cap();
      ext_trig_r <= 1'b0;
      repeat (3) @(posedge i_clk);
      ext_trig_r <= 1'b1;
      dec(1'b1);
      wait_end();
      check(cap_n - n0, 33'h1);
      ext_trig_r <= 1'b0;
      apb(1'b1, stc_pkg::OFS_CTRL, 32'hB);
      exp_q.push_back(3'b100);
      ext_trig_r <= 1'b1;
      wait_cap();
      repeat (4) @(posedge i_clk);
      ext_trig_r <= 1'b0;
      wait_end();
      exp_q.push_back(3'b010);
      ext_trig_r <= 1'b1;
      wait_cap();
      dec(1'b1);
      wait_end();
      repeat (4) @(posedge i_clk);
      ext_trig_r <= 1'b0;
      repeat (4) @(posedge i_clk);
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, stc_pkg::OFS_CTRL, m ? 32'h7 : 32'h3);
         exp_q.push_back(3'b001);
         pulse();
         wait_cap();
         n0 = cap_n;
         dec(1'b0);
         if (m) wait_cap();
         if (m) dec(1'b0);
         wait_end();
         repeat (5) @(posedge i_clk);
         check(cap_n - n0, m);
      end
      apb(1'b1, stc_pkg::OFS_CTRL, 32'hF);
      exp_q.push_back(3'b100);
      host_u.send(1'b0, stc_pkg::BYTE_ON, 16'h0, $urandom % 4);
      wait_cap();
      host_u.send(1'b0, stc_pkg::BYTE_OFF, 16'h0, $urandom % 4);
      wait_end();
      n0 = cap_n;
      host_u.send(1'b1, stc_pkg::BYTE_ON, 16'h1234, 0);
      repeat (20) @(posedge i_clk);
      check(cap_n - n0, 33'h0);
      exp_q.push_back(3'b001);
      host_u.send(1'b1, stc_pkg::BYTE_ON, 16'hD7D8, 1);
      wait_cap();
      wait_end();
      ends_on = 1'b0;
      apb(1'b1, stc_pkg::OFS_CTRL, 32'h1);
      n0 = cap_n;
      repeat (450) @(posedge i_clk);
      check({32'h0, cap_n - n0 >= 2 && cap_n - n0 <= 3}, 33'h1);
      apb(1'b1, stc_pkg::OFS_CTRL, 32'h0);
      repeat (5) @(posedge i_clk);
      n0 = cap_n;
      repeat (300) @(posedge i_clk);
      check(cap_n - n0, 33'h0);
      check(exp_q.size(), 33'h0);
      stop_test();
   end
endmodule // scan_trigger_controller_tb_top
